/* File: core/vendor_opt_pkg.sv */
`default_nettype none
package vendor_opt_pkg;
  // register select codes on the register port
  localparam logic [2:0] SEL_PKT_CTRL = 3'h0;
  localparam logic [2:0] SEL_NODE_IDS = 3'h1;
  localparam logic [2:0] SEL_ATTACH = 3'h2;
  localparam logic [2:0] SEL_RST_RESP = 3'h3;
  localparam logic [2:0] SEL_ARB_LIM = 3'h4;
  localparam logic [2:0] SEL_FORCED_TOP = 3'h5;
  localparam logic [2:0] SEL_BIAS_EXCH = 3'h6;
  localparam logic [2:0] SEL_BIAS_DEB = 3'h7;

  // packet handling control bit positions
  localparam int BIT_EXT_TICK = 23;
  localparam int BIT_INV_CHECK = 9;
  localparam int BIT_RST_PKT = 8;
  localparam int BIT_CONCAT = 7;
  localparam int BIT_REMOTE = 4;
  localparam int BIT_PING = 2;
  localparam int BIT_LINK_GATE = 1;
  localparam int BIT_PHY_CFG = 0;
  localparam logic [31:0] PKT_CTRL_MASK = 32'h0080_0397;
  localparam logic [31:0] PKT_CTRL_RESET = 32'h0000_0114;

  // node id fields
  localparam int TOP_LSB = 8;
  localparam int RM_LSB = 0;
  localparam logic [5:0] TOP_RESET = 6'h00;
  localparam logic [5:0] RM_RESET = 6'h3F;

  // timer registers: enable at 31, long field 24:11, short field 15:0
  localparam int BIT_TMR_EN = 31;
  localparam int LONG_LSB = 11;
  localparam logic [31:0] LONG_MASK = 32'h81FF_F800;
  localparam logic [31:0] SHORT_MASK = 32'h8000_FFFF;
  localparam logic [31:0] ATTACH_RESET = 32'h8000_0000 | (32'h0A80 << 11);
  localparam logic [31:0] RST_RESP_RESET = 32'h8000_0000 | (32'h0280 << 11);
  localparam logic [31:0] ARB_LIM_RESET = 32'h8000_2710;
  localparam logic [31:0] FORCED_TOP_RESET = 32'h8000_0F8D;
  localparam logic [31:0] BIAS_EXCH_RESET = 32'h8000_0000 | (32'h002B << 11);
  localparam logic [31:0] BIAS_DEB_RESET = 32'h8000_0410;

  // timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int FINE_TICK_PS = 40000;
  localparam int COARSE_TICK_NS = 125000;
  localparam int FINE_TICK_CYCLES = FINE_TICK_PS / CLK_PERIOD_PS;
  localparam int COARSE_TICK_CYCLES = COARSE_TICK_NS * 1000 / CLK_PERIOD_PS;
  localparam logic [12:0] CYCLE_COUNT_LAST = 13'h1F3F;

  typedef struct packed {
    logic extTickSel;
    logic invCheck;
    logic resetPktGen;
    logic concat;
    logic remoteAuto;
    logic pingAuto;
    logic linkGate;
    logic phyCfgAuto;
  } pkt_ctrl_t;

  typedef struct packed {
    logic [5:0] gapCount;
    logic rootHoldoff;
  } phy_cfg_t;
endpackage
`default_nettype wire

/* File: core/interval_timer.sv */
`default_nettype none
module interval_timer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic start,
  input wire logic tick,
  input wire logic [15:0] limit,
  output logic expire
);
  logic running_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic hit;

  assign count_nxt = count_r + 16'h0001;
  assign hit = running_r && enable && tick && (count_nxt == limit);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      running_r <= 1'b0;
      count_r <= 16'h0000;
      expire <= 1'b0;
    end else begin
      expire <= hit;
      if (start) begin
        running_r <= enable;
        count_r <= 16'h0000;
      end else if (!enable || hit) begin
        running_r <= 1'b0;
      end else if (running_r && tick) begin
        count_r <= count_nxt;
      end
    end
  end
endmodule // interval_timer
`default_nettype wire

/* File: core/serial_bus_vendor_option_regs.sv */
// What this block does
// - with cycle source select, bit 23 picks external or internal 8 kHz cycle tick
// - bit 9 set: received phy packet checked against its inverted quadlet
// - bit 8 set, reset one: bus reset packet generated on reset response
// - bit 7 set: outgoing packets are concatenated
// - bit 4 set: remote access and command packets get automatic replies
// - bit 2 set: ping packet triggers self identification transmit
// - bit 1 set: link traffic only after link-on; else host enable suffices
// - bit 0 set: phy config packet overwrites gap count and root holdoff
// - read-only top node number 13:8 and resource manager number 5:0
// - attach detect interval in 24:11, 125 us units, reset 0A80h
// - reset response delay in 24:11, 125 us units, reset 0280h
// - arbitration state over limit in 15:0, 40 ns ticks, sets timeout status
// - forced-top delay 15:0, 40 ns ticks, from root holdoff to tree id
// - bias exchange interval 24:11, 125 us units, reset 002Bh, times one span from start to done
// - peer bias filtered by 15:0 interval before bias bit sets
// - bit 31 of each timer register enables it, reset one
`default_nettype none
module serial_bus_vendor_option_regs #(
  parameter int COARSE_CYCLES = vendor_opt_pkg::COARSE_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wrEn,
  input wire logic [2:0] wrSel,
  input wire logic [31:0] wrData,
  input wire logic rdEn,
  input wire logic [2:0] rdSel,
  output logic [31:0] rdData,
  input wire logic cycleSourceSelect,
  input wire logic externalCycleTick,
  output logic [12:0] cycleCounter,
  input wire logic phyPktValid,
  input wire logic [63:0] phyPktData,
  output logic phyPktAccept,
  output logic phyPktReject,
  output logic concatEnable,
  input wire logic remoteAccessRx,
  input wire logic remoteCommandRx,
  output logic remoteReplyTx,
  output logic remoteConfirmTx,
  input wire logic pingRx,
  output logic selfIdTx,
  input wire logic hostLinkEnable,
  input wire logic linkOnRx,
  output logic linkTrafficEnable,
  input wire logic phyConfigRx,
  input wire vendor_opt_pkg::phy_cfg_t phyConfigIn,
  output vendor_opt_pkg::phy_cfg_t phyRegCfg,
  input wire logic nodeIdsValid,
  input wire logic [5:0] topNodeIn,
  input wire logic [5:0] rmNodeIn,
  input wire logic attachStart,
  output logic attachTimeout,
  input wire logic busResetRx,
  output logic busResetRespond,
  output logic resetPktTx,
  input wire logic arbStateChange,
  input wire logic timeoutClear,
  output logic phyTimeoutStatus,
  output logic treeIdStart,
  input wire logic biasExchStart,
  output logic biasExchDone,
  input wire logic peerBiasDetect,
  input wire logic peerBiasLost,
  output logic cablePairBias
);
  logic [31:0] pktCtrl_r;
  logic [5:0] topNode_r;
  logic [5:0] rmNode_r;
  logic [31:0] tmr_r [2:7];
  vendor_opt_pkg::pkt_ctrl_t ctl;
  logic [15:0] fineCnt_r;
  logic [15:0] coarseCnt_r;
  logic fineTick_r;
  logic coarseTick_r;
  logic extTickPrev_r;
  logic extTickRise;
  logic cycleTick;
  logic linkOnSeen_r;
  logic invOk;
  logic rootHoldoffPrev_r;
  logic attachExp;
  logic respExp;
  logic arbExp;
  logic topExp;
  logic exchExp;
  logic debExp;
  logic [31:0] rdMux;

  assign ctl.extTickSel = pktCtrl_r[vendor_opt_pkg::BIT_EXT_TICK];
  assign ctl.invCheck = pktCtrl_r[vendor_opt_pkg::BIT_INV_CHECK];
  assign ctl.resetPktGen = pktCtrl_r[vendor_opt_pkg::BIT_RST_PKT];
  assign ctl.concat = pktCtrl_r[vendor_opt_pkg::BIT_CONCAT];
  assign ctl.remoteAuto = pktCtrl_r[vendor_opt_pkg::BIT_REMOTE];
  assign ctl.pingAuto = pktCtrl_r[vendor_opt_pkg::BIT_PING];
  assign ctl.linkGate = pktCtrl_r[vendor_opt_pkg::BIT_LINK_GATE];
  assign ctl.phyCfgAuto = pktCtrl_r[vendor_opt_pkg::BIT_PHY_CFG];

  // register writes; node ids are read-only and ignore writes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pktCtrl_r <= vendor_opt_pkg::PKT_CTRL_RESET;
      tmr_r[2] <= vendor_opt_pkg::ATTACH_RESET;
      tmr_r[3] <= vendor_opt_pkg::RST_RESP_RESET;
      tmr_r[4] <= vendor_opt_pkg::ARB_LIM_RESET;
      tmr_r[5] <= vendor_opt_pkg::FORCED_TOP_RESET;
      tmr_r[6] <= vendor_opt_pkg::BIAS_EXCH_RESET;
      tmr_r[7] <= vendor_opt_pkg::BIAS_DEB_RESET;
    end else if (wrEn) begin
      unique case (wrSel)
        vendor_opt_pkg::SEL_PKT_CTRL: pktCtrl_r <= wrData & vendor_opt_pkg::PKT_CTRL_MASK;
        vendor_opt_pkg::SEL_NODE_IDS: ;
        vendor_opt_pkg::SEL_ATTACH: tmr_r[2] <= wrData & vendor_opt_pkg::LONG_MASK;
        vendor_opt_pkg::SEL_RST_RESP: tmr_r[3] <= wrData & vendor_opt_pkg::LONG_MASK;
        vendor_opt_pkg::SEL_ARB_LIM: tmr_r[4] <= wrData & vendor_opt_pkg::SHORT_MASK;
        vendor_opt_pkg::SEL_FORCED_TOP: tmr_r[5] <= wrData & vendor_opt_pkg::SHORT_MASK;
        // enable at 31 governs the 24:11 field here too
        vendor_opt_pkg::SEL_BIAS_EXCH: tmr_r[6] <= wrData & vendor_opt_pkg::LONG_MASK;
        vendor_opt_pkg::SEL_BIAS_DEB: tmr_r[7] <= wrData & vendor_opt_pkg::SHORT_MASK;
      endcase
    end
  end

  // top node has no defined reset value; zero keeps simulation clean
  always_ff @(posedge clk) begin
    if (!nrst) begin
      topNode_r <= vendor_opt_pkg::TOP_RESET;
      rmNode_r <= vendor_opt_pkg::RM_RESET;
    end else if (nodeIdsValid) begin
      topNode_r <= topNodeIn;
      rmNode_r <= rmNodeIn;
    end
  end

  assign rdMux = (rdSel == vendor_opt_pkg::SEL_PKT_CTRL) ? pktCtrl_r :
                 (rdSel == vendor_opt_pkg::SEL_NODE_IDS) ?
                   ({26'h0000000, topNode_r} << vendor_opt_pkg::TOP_LSB) |
                   ({26'h0000000, rmNode_r} << vendor_opt_pkg::RM_LSB) :
                 tmr_r[rdSel];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdData <= 32'h0000_0000;
    end else if (rdEn) begin
      rdData <= rdMux;
    end
  end

  // tick dividers: 40 ns fine tick and 125 us coarse tick
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fineCnt_r <= 16'h0000;
      coarseCnt_r <= 16'h0000;
      fineTick_r <= 1'b0;
      coarseTick_r <= 1'b0;
    end else begin
      fineTick_r <= (fineCnt_r == 16'(vendor_opt_pkg::FINE_TICK_CYCLES - 1));
      coarseTick_r <= (coarseCnt_r == 16'(COARSE_CYCLES - 1));
      fineCnt_r <= fineTick_r ? 16'h0001 :
        ((fineCnt_r == 16'(vendor_opt_pkg::FINE_TICK_CYCLES - 1)) ? 16'h0000
                                                                   : fineCnt_r + 16'h0001);
      coarseCnt_r <= (coarseCnt_r == 16'(COARSE_CYCLES - 1)) ? 16'h0000
                                                             : coarseCnt_r + 16'h0001;
    end
  end

  // cycle counter source choice
  assign extTickRise = externalCycleTick && !extTickPrev_r;
  assign cycleTick = (cycleSourceSelect && ctl.extTickSel) ? extTickRise : coarseTick_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      extTickPrev_r <= 1'b0;
      cycleCounter <= 13'h0000;
    end else begin
      extTickPrev_r <= externalCycleTick;
      if (cycleTick) begin
        cycleCounter <= (cycleCounter == vendor_opt_pkg::CYCLE_COUNT_LAST) ? 13'h0000
                                                                           : cycleCounter + 13'h0001;
      end
    end
  end

  // phy packet inverse check; with checking off every packet passes
  assign invOk = (phyPktData[31:0] == ~phyPktData[63:32]);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      phyPktAccept <= 1'b0;
      phyPktReject <= 1'b0;
      remoteReplyTx <= 1'b0;
      remoteConfirmTx <= 1'b0;
      selfIdTx <= 1'b0;
      concatEnable <= 1'b0;
    end else begin
      phyPktAccept <= phyPktValid && (!ctl.invCheck || invOk);
      phyPktReject <= phyPktValid && ctl.invCheck && !invOk;
      remoteReplyTx <= remoteAccessRx && ctl.remoteAuto;
      remoteConfirmTx <= remoteCommandRx && ctl.remoteAuto;
      selfIdTx <= pingRx && ctl.pingAuto;
      concatEnable <= ctl.concat;
    end
  end

  // link-on gating; a bus reset forgets an earlier link-on
  always_ff @(posedge clk) begin
    if (!nrst) begin
      linkOnSeen_r <= 1'b0;
      linkTrafficEnable <= 1'b0;
    end else begin
      if (linkOnRx) begin
        linkOnSeen_r <= 1'b1;
      end else if (busResetRx) begin
        linkOnSeen_r <= 1'b0;
      end
      linkTrafficEnable <= hostLinkEnable && (!ctl.linkGate || linkOnSeen_r);
    end
  end

  // phy register gap count and root holdoff
  always_ff @(posedge clk) begin
    if (!nrst) begin
      phyRegCfg <= '0;
      rootHoldoffPrev_r <= 1'b0;
    end else begin
      rootHoldoffPrev_r <= phyRegCfg.rootHoldoff;
      if (phyConfigRx && ctl.phyCfgAuto) begin
        phyRegCfg <= phyConfigIn;
      end
    end
  end

  interval_timer attachTmr (
    .clk(clk), .nrst(nrst),
    .enable(tmr_r[2][vendor_opt_pkg::BIT_TMR_EN]),
    .start(attachStart), .tick(coarseTick_r),
    .limit({2'b00, tmr_r[2][24:11]}),
    .expire(attachExp)
  );
  interval_timer respTmr (
    .clk(clk), .nrst(nrst),
    .enable(tmr_r[3][vendor_opt_pkg::BIT_TMR_EN]),
    .start(busResetRx), .tick(coarseTick_r),
    .limit({2'b00, tmr_r[3][24:11]}),
    .expire(respExp)
  );
  // restarts on every arbitration state change
  interval_timer arbTmr (
    .clk(clk), .nrst(nrst),
    .enable(tmr_r[4][vendor_opt_pkg::BIT_TMR_EN]),
    .start(arbStateChange), .tick(fineTick_r),
    .limit(tmr_r[4][15:0]),
    .expire(arbExp)
  );
  interval_timer topTmr (
    .clk(clk), .nrst(nrst),
    .enable(tmr_r[5][vendor_opt_pkg::BIT_TMR_EN]),
    .start(phyRegCfg.rootHoldoff && !rootHoldoffPrev_r), .tick(fineTick_r),
    .limit(tmr_r[5][15:0]),
    .expire(topExp)
  );
  interval_timer exchTmr (
    .clk(clk), .nrst(nrst),
    .enable(tmr_r[6][vendor_opt_pkg::BIT_TMR_EN]),
    .start(biasExchStart), .tick(coarseTick_r),
    .limit({2'b00, tmr_r[6][24:11]}),
    .expire(exchExp)
  );
  interval_timer debTmr (
    .clk(clk), .nrst(nrst),
    .enable(tmr_r[7][vendor_opt_pkg::BIT_TMR_EN]),
    .start(peerBiasDetect), .tick(fineTick_r),
    .limit(tmr_r[7][15:0]),
    .expire(debExp)
  );

  // timer results; the timeout set wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      attachTimeout <= 1'b0;
      busResetRespond <= 1'b0;
      resetPktTx <= 1'b0;
      phyTimeoutStatus <= 1'b0;
      treeIdStart <= 1'b0;
      biasExchDone <= 1'b0;
      cablePairBias <= 1'b0;
    end else begin
      attachTimeout <= attachExp;
      busResetRespond <= respExp;
      resetPktTx <= respExp && ctl.resetPktGen;
      if (arbExp) begin
        phyTimeoutStatus <= 1'b1;
      end else if (timeoutClear) begin
        phyTimeoutStatus <= 1'b0;
      end
      treeIdStart <= topExp;
      biasExchDone <= exchExp;
      if (debExp) begin
        cablePairBias <= 1'b1;
      end else if (peerBiasLost) begin
        cablePairBias <= 1'b0;
      end
    end
  end
endmodule // serial_bus_vendor_option_regs
`default_nettype wire

/* File: dv/vendor_opt_monitor.sv */
`default_nettype none
module vendor_opt_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic wrEn,
  input wire logic [2:0] wrSel,
  input wire logic [31:0] wrData,
  input wire logic rdEn,
  input wire logic [2:0] rdSel,
  input wire logic [31:0] rdData,
  input wire logic phyPktValid,
  input wire logic [63:0] phyPktData,
  input wire logic phyPktAccept,
  input wire logic phyPktReject,
  input wire logic concatEnable,
  input wire logic remoteAccessRx,
  input wire logic remoteCommandRx,
  input wire logic remoteReplyTx,
  input wire logic remoteConfirmTx,
  input wire logic pingRx,
  input wire logic selfIdTx,
  input wire logic hostLinkEnable,
  input wire logic linkTrafficEnable,
  input wire logic busResetRespond,
  input wire logic resetPktTx
);
  logic [31:0] ctrl_r;
  logic rejWant;
  // shadow of the control word, so gating is judged on what software wrote
  assign rejWant = ctrl_r[9] && (phyPktData[31:0] != ~phyPktData[63:32]);
  always_ff @(posedge clk) begin
    if (!nrst)
      ctrl_r <= vendor_opt_pkg::PKT_CTRL_RESET;
    else if (wrEn && wrSel == vendor_opt_pkg::SEL_PKT_CTRL)
      ctrl_r <= wrData & vendor_opt_pkg::PKT_CTRL_MASK;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ping_reply_a: assert property (pingRx |=> selfIdTx == $past(ctrl_r[2]))
    else $error("ping reply mismatch");
  remote_reply_a: assert property (remoteAccessRx |=> remoteReplyTx == $past(ctrl_r[4]))
    else $error("remote reply mismatch");
  remote_confirm_a: assert property (remoteCommandRx |=> remoteConfirmTx == $past(ctrl_r[4]))
    else $error("remote confirm mismatch");
  concat_level_a: assert property (ctrl_r[7] == $past(ctrl_r[7]) |-> concatEnable == ctrl_r[7])
    else $error("concat level mismatch");
  inv_check_a: assert property (phyPktValid |=> phyPktReject == $past(rejWant)
    && phyPktAccept == !$past(rejWant)) else $error("inverse check mismatch");
  link_host_a: assert property (!hostLinkEnable [*2] |-> !linkTrafficEnable)
    else $error("link traffic without host enable");
  reset_pkt_a: assert property (busResetRespond || resetPktTx
    |-> resetPktTx == (busResetRespond && $past(ctrl_r[8]))) else $error("reset packet mismatch");
  ctrl_read_a: assert property (rdEn && rdSel == vendor_opt_pkg::SEL_PKT_CTRL
    |=> rdData == $past(ctrl_r)) else $error("control readback mismatch");
  cover property (pingRx && ctrl_r[2]);
  cover property (phyPktValid && rejWant);
  cover property (busResetRespond && resetPktTx);
endmodule // vendor_opt_monitor
bind serial_bus_vendor_option_regs vendor_opt_monitor i_mon (.clk, .nrst, .wrEn, .wrSel,
  .wrData, .rdEn, .rdSel, .rdData, .phyPktValid, .phyPktData, .phyPktAccept, .phyPktReject,
  .concatEnable, .remoteAccessRx, .remoteCommandRx, .remoteReplyTx, .remoteConfirmTx,
  .pingRx, .selfIdTx, .hostLinkEnable, .linkTrafficEnable, .busResetRespond, .resetPktTx);
`default_nettype wire

/* File: dv/cable_peer.sv */
`default_nettype none
module cable_peer (
  input wire logic clk,
  output logic pingRx,
  output logic remoteAccessRx,
  output logic remoteCommandRx,
  output logic linkOnRx,
  output logic phyConfigRx,
  output logic phyPktValid,
  output logic busResetRx,
  output logic peerBiasDetect,
  output var vendor_opt_pkg::phy_cfg_t phyConfigIn,
  output logic [63:0] phyPktData
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] ev = 8'h00;
  assign {peerBiasDetect, busResetRx, phyPktValid, phyConfigRx} = ev[7:4];
  assign {linkOnRx, remoteCommandRx, remoteAccessRx, pingRx} = ev[3:0];
  initial begin
    phyPktData = 64'h0;
    phyConfigIn = 7'h00;
  end
  // released lines show the inverse, never a stale copy
  task automatic send(input int kind, input logic [63:0] d);
    @(posedge clk);
    ev <= 8'h01 << kind;
    phyPktData <= d;
    phyConfigIn <= d[6:0];
    @(posedge clk);
    ev <= 8'h00;
    phyPktData <= ~d;
    phyConfigIn <= ~d[6:0];
  endtask
endmodule // cable_peer
`default_nettype wire

/* File: dv/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, nrst = 1'b0, wrEn = 1'b0, rdEn = 1'b0;
  logic [2:0] wrSel = 3'h0, rdSel = 3'h0;
  logic [31:0] wrData = 32'h0, rdData, v;
  logic cycleSourceSelect = 1'b0, externalCycleTick = 1'b0, hostLinkEnable = 1'b0;
  logic nodeIdsValid = 1'b0, attachStart = 1'b0, arbStateChange = 1'b0, timeoutClear = 1'b0;
  logic biasExchStart = 1'b0, peerBiasLost = 1'b0;
  logic [5:0] topNodeIn = 6'h00, rmNodeIn = 6'h00;
  logic phyPktValid, remoteAccessRx, remoteCommandRx, pingRx, linkOnRx, phyConfigRx;
  logic busResetRx, peerBiasDetect, phyPktAccept, phyPktReject, concatEnable, selfIdTx;
  logic remoteReplyTx, remoteConfirmTx, linkTrafficEnable, attachTimeout, busResetRespond;
  logic resetPktTx, phyTimeoutStatus, treeIdStart, biasExchDone, cablePairBias;
  logic [63:0] phyPktData;
  logic [12:0] cycleCounter, c0;
  vendor_opt_pkg::phy_cfg_t phyConfigIn, phyRegCfg;
  int err_total = 0, total_checks = 0, n;
  logic [31:0] rstVal [8] = '{32'h0000_0114, 32'h0000_003F, 32'h8054_0000, 32'h8014_0000,
    32'h8000_2710, 32'h8000_0F8D, 32'h8001_5800, 32'h8000_0410};
  serial_bus_vendor_option_regs #(.COARSE_CYCLES(20)) i_dut (.clk, .nrst, .wrEn, .wrSel,
    .wrData, .rdEn, .rdSel, .rdData, .cycleSourceSelect, .externalCycleTick, .cycleCounter,
    .phyPktValid, .phyPktData, .phyPktAccept, .phyPktReject, .concatEnable, .remoteAccessRx,
    .remoteCommandRx, .remoteReplyTx, .remoteConfirmTx, .pingRx, .selfIdTx, .hostLinkEnable,
    .linkOnRx, .linkTrafficEnable, .phyConfigRx, .phyConfigIn, .phyRegCfg, .nodeIdsValid,
    .topNodeIn, .rmNodeIn, .attachStart, .attachTimeout, .busResetRx, .busResetRespond,
    .resetPktTx, .arbStateChange, .timeoutClear, .phyTimeoutStatus, .treeIdStart,
    .biasExchStart, .biasExchDone, .peerBiasDetect, .peerBiasLost, .cablePairBias);
  cable_peer i_peer (.clk, .pingRx, .remoteAccessRx, .remoteCommandRx, .linkOnRx,
    .phyConfigRx, .phyPktValid, .busResetRx, .peerBiasDetect, .phyConfigIn, .phyPktData);
  always #2 clk = ~clk;
  task automatic stop_test();
    if (err_total == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    @(posedge clk);
    wrEn <= 1'b1;
    wrSel <= s;
    wrData <= d;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask
  task automatic rdc(input logic [2:0] s, input logic [31:0] e);
    @(posedge clk);
    rdEn <= 1'b1;
    rdSel <= s;
    @(posedge clk);
    rdEn <= 1'b0;
    @(posedge clk);
    #1 chk("rdData", e, rdData);
  endtask
  task automatic hit(input int k);
    @(posedge clk);
    arbStateChange <= (k == 0);
    timeoutClear <= (k == 1);
    nodeIdsValid <= (k == 2);
    attachStart <= (k == 3);
    biasExchStart <= (k == 4);
    peerBiasLost <= (k == 5);
    topNodeIn <= 6'h15;
    rmNodeIn <= 6'h09;
    @(posedge clk);
    {arbStateChange, timeoutClear, nodeIdsValid, attachStart, biasExchStart, peerBiasLost} <= 6'h00;
  endtask
  // pulses are looked at 1 ns after each edge, so a one-cycle pulse is not missed
  task automatic waitHi(ref logic s, input int lim, output int cnt);
    cnt = 0;
    while (s !== 1'b1) begin
      @(posedge clk);
      #1 cnt++;
      if (cnt > lim) begin
        err_total++;
        stop_test();
      end
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    cycleSourceSelect <= 1'b1;
    for (int s = 0; s < 8; s++) rdc(3'(s), rstVal[s]);
    i_peer.send(7, 64'h0);
    waitHi(cablePairBias, 10500, n);
    chk("biasDelay", 32'h1, 32'(n > 10390 && n < 10404));
    wr(vendor_opt_pkg::SEL_FORCED_TOP, 32'h8000_0002); // nonzero interval
    for (int i = 0; i < 2; i++) begin
      v = i ? 32'h0 : vendor_opt_pkg::PKT_CTRL_MASK;
      wr(vendor_opt_pkg::SEL_PKT_CTRL, v | 32'hFF7F_FC68); // gating cleared on i=1
      rdc(vendor_opt_pkg::SEL_PKT_CTRL, v);
      chk("concatEnable", 32'(v[7]), 32'(concatEnable));
      for (int k = 0; k < 3; k++) begin
        i_peer.send(k, 64'h0);
        #1 chk("replies", 32'({v[4], v[4], v[2]} & (3'h1 << k)),
          32'({remoteConfirmTx, remoteReplyTx, selfIdTx}));
      end
      i_peer.send(5, 64'h1234_5678_EDCB_A987);
      #1 chk("goodPkt", 32'h2, 32'({phyPktAccept, phyPktReject}));
      i_peer.send(5, 64'h1234_5678_1234_5678);
      #1 chk("badPkt", i ? 32'h2 : 32'h1, 32'({phyPktAccept, phyPktReject}));
      i_peer.send(4, i ? 64'h2A : 64'h55);
      repeat (2) @(posedge clk);
      #1 chk("phyRegCfg", 32'h55, 32'(phyRegCfg));
      if (i == 0) begin
        waitHi(treeIdStart, 30, n);
        c0 = cycleCounter;
        repeat (3) begin
          @(posedge clk) externalCycleTick <= 1'b1;
          repeat (2) @(posedge clk);
          externalCycleTick <= 1'b0;
          repeat (2) @(posedge clk);
        end
        repeat (4) @(posedge clk);
        #1 chk("cycleCounter", 32'(c0 + 13'h3), 32'(cycleCounter));
      end
    end
    c0 = cycleCounter;
    repeat (40) @(posedge clk);
    #1 chk("cycleInternal", 32'(c0 + 13'h2), 32'(cycleCounter));
    @(posedge clk) hostLinkEnable <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("linkOpen", 32'h1, 32'(linkTrafficEnable));
    wr(vendor_opt_pkg::SEL_PKT_CTRL, 32'h0000_0102);
    repeat (3) @(posedge clk);
    #1 chk("linkGated", 32'h0, 32'(linkTrafficEnable));
    i_peer.send(3, 64'h0);
    repeat (2) @(posedge clk);
    #1 chk("linkOnSeen", 32'h1, 32'(linkTrafficEnable));
    wr(vendor_opt_pkg::SEL_RST_RESP, 32'h8000_0800); // one coarse tick
    i_peer.send(6, 64'h0);
    waitHi(busResetRespond, 30, n);
    chk("resetPkt", 32'h1, 32'(resetPktTx));
    chk("respDelay", 32'h1, 32'(n >= 1 && n <= 23));
    repeat (3) @(posedge clk);
    #1 chk("linkAfterReset", 32'h0, 32'(linkTrafficEnable));
    chk("status", 32'h0, 32'(phyTimeoutStatus));
    wr(vendor_opt_pkg::SEL_ARB_LIM, 32'h8000_0003);
    hit(0);
    waitHi(phyTimeoutStatus, 40, n);
    chk("arbDelay", 32'h1, 32'(n >= 21 && n <= 33));
    hit(1);
    wr(vendor_opt_pkg::SEL_ARB_LIM, 32'h0000_0003);
    hit(0);
    repeat (50) @(posedge clk);
    #1 chk("disabledArb", 32'h0, 32'(phyTimeoutStatus));
    wr(vendor_opt_pkg::SEL_ATTACH, 32'h8000_1000); // two coarse ticks
    hit(3);
    waitHi(attachTimeout, 60, n);
    chk("attachDelay", 32'h1, 32'(n >= 23 && n <= 42));
    wr(vendor_opt_pkg::SEL_BIAS_EXCH, 32'h8000_0800); // one coarse tick
    hit(4);
    waitHi(biasExchDone, 30, n);
    chk("exchDelay", 32'h1, 32'(n >= 3 && n <= 22));
    hit(5);
    #1 chk("biasLost", 32'h0, 32'(cablePairBias));
    hit(2);
    wr(vendor_opt_pkg::SEL_NODE_IDS, 32'hFFFF_FFFF);
    rdc(vendor_opt_pkg::SEL_NODE_IDS, 32'h0000_1509);
    for (int s = 2; s < 8; s++) begin
      wr(3'(s), 32'hFFFF_FFFF);
      rdc(3'(s), (s == 2 || s == 3 || s == 6) ? vendor_opt_pkg::LONG_MASK :
        vendor_opt_pkg::SHORT_MASK);
    end
    stop_test();
  end
endmodule // tb
`default_nettype wire
